// ### include/mm_pkg.sv
// Shared constants and types for the transceiver management control block.
// Assumes a 125 MHz core clock and a host-clocked 2-wire serial link.
package mm_pkg;

  // Core clock rate
  localparam int unsigned CORE_CLK_KHZ   = 125000;

  // Response limits
  localparam int unsigned MASK_TIME_MS   = 100;  // Mask set or cleared to effect
  localparam int unsigned SEL_TIME_US    = 100;  // Select to answer, deselect to quiet
  localparam int unsigned PDOWN_TIME_MS  = 100;  // Power-down bit to lower power level
  localparam int unsigned WAKE_TIME_MS   = 300;  // Power-down cleared to fully functional
  localparam int unsigned FLAG_TIME_MS   = 200;  // Condition to flag and interrupt

  // Longest wait, in core cycles; rounded down as it is a longest time
  localparam int unsigned WAKE_CYCLES    = WAKE_TIME_MS * CORE_CLK_KHZ;

  // Memory map of the serial bus
  localparam logic [7:0]  STATUS_OFS     = 8'h02;  // Status byte
  localparam logic [7:0]  FLAG_OFS       = 8'h03;  // Latched flags, clear on read
  localparam logic [7:0]  PWR_OFS        = 8'h10;  // Power control byte, placement arbitrary
  localparam logic [7:0]  MASK_OFS       = 8'h11;  // Flag mask byte, placement arbitrary
  localparam int unsigned DNR_BIT        = 0;      // Data-not-ready in status byte
  localparam int unsigned PDOWN_BIT      = 0;      // Power-down in power control byte
  localparam logic [7:0]  FLAG_RESET     = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'h00;

  // Bus address of the module, 7 bits
  localparam logic [6:0]  DEV_ADDR       = 7'h3a;  // Arbitrary value

  // Byte offset and data handed from the link to the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } mm_req_t;

  // Serial slave states
  typedef enum logic [3:0] {
    TS_IDLE      = 4'h0,
    TS_ADDR      = 4'h1,
    TS_ADDR_ACK  = 4'h2,
    TS_OFFS      = 4'h3,
    TS_OFFS_ACK  = 4'h4,
    TS_WDATA     = 4'h5,
    TS_WDATA_ACK = 4'h6,
    TS_RDATA     = 4'h7,
    TS_RACK      = 4'h8
  } mm_twi_state_t;

  // Power states
  typedef enum logic [1:0] {
    PS_FULL = 2'h0,
    PS_LOW  = 2'h1,
    PS_WAKE = 2'h2
  } mm_pwr_state_t;

endpackage

// ### design/mm_twi_slave.sv
// 2-wire serial slave running on the host's serial clock.
// Assumes sda changes only while scl is low, except at start and stop.
`timescale 1ns/1ns
`default_nettype none

module mm_twi_slave
(
  input  wire logic           scl_clk,       // Serial clock from the host
  input  wire logic           resetn,        // Asynchronous, active low
  input  wire logic           sda_in,        // Data line level
  input  wire logic           select_n,      // Module select pin, raw
  input  wire logic [7:0]     rd_byte,       // Core byte at req.addr, quasi-static
  output logic                sda_drive,     // High while pulling sda low
  output mm_pkg::mm_req_t     req,           // Offset and last written byte
  output logic                wr_tgl,        // Flips once per written byte
  output logic                rd_tgl         // Flips once per byte loaded for reading
);

  logic                  sda_p;              // Data sampled at the rising edge
  logic                  sel_s1;             // Select synchroniser, first stage
  logic                  sel_s2;             // Select synchroniser, second stage
  mm_pkg::mm_twi_state_t state;
  mm_pkg::mm_twi_state_t next_state;
  logic [7:0]            shreg;              // Shift register, both directions
  logic [7:0]            next_shreg;
  logic [2:0]            cnt;                // Bit count within a byte
  logic [2:0]            next_cnt;
  logic                  next_drive;
  mm_pkg::mm_req_t       next_req;
  logic                  next_wr_tgl;
  logic                  next_rd_tgl;
  logic [7:0]            byte_in;            // Byte as completed by this edge
  logic                  sel_ok;             // Module selected, in this domain

  assign byte_in = {shreg[6:0], sda_p};
  assign sel_ok  = ~sel_s2;

  // Data bits are valid at the rising edge
  always_ff @(posedge scl_clk or negedge resetn)
  begin
    if (!resetn)
      sda_p <= 1'b1;
    else
      sda_p <= sda_in;
  end

  // Protocol decode; start and stop show as sda differing between rise and fall
  always_comb
  begin
    next_state  = state;
    next_shreg  = shreg;
    next_cnt    = cnt;
    next_drive  = sda_drive;
    next_req    = req;
    next_wr_tgl = wr_tgl;
    next_rd_tgl = rd_tgl;
    case (state)
      mm_pkg::TS_IDLE:
        next_drive = 1'b0;
      mm_pkg::TS_ADDR:
      begin
        next_shreg = byte_in;
        next_cnt   = cnt + 3'h1;
        if (cnt == 3'h7)
        begin
          // Deselected modules leave the bus free
          if (byte_in[7:1] == mm_pkg::DEV_ADDR && sel_ok)
          begin
            next_state = mm_pkg::TS_ADDR_ACK;
            next_drive = 1'b1;
          end
          else
            next_state = mm_pkg::TS_IDLE;
        end
      end
      mm_pkg::TS_ADDR_ACK:
      begin
        next_cnt = 3'h0;
        if (shreg[0])
        begin
          // Read: load the first byte and present its top bit
          next_shreg  = rd_byte;
          next_drive  = ~rd_byte[7] & sel_ok;
          next_rd_tgl = ~rd_tgl;
          next_state  = mm_pkg::TS_RDATA;
        end
        else
        begin
          next_drive = 1'b0;
          next_state = mm_pkg::TS_OFFS;
        end
      end
      mm_pkg::TS_OFFS:
      begin
        next_shreg = byte_in;
        next_cnt   = cnt + 3'h1;
        if (cnt == 3'h7)
        begin
          next_req.addr = byte_in;
          next_drive    = sel_ok;
          next_state    = mm_pkg::TS_OFFS_ACK;
        end
      end
      mm_pkg::TS_OFFS_ACK:
      begin
        next_drive = 1'b0;
        next_state = mm_pkg::TS_WDATA;
      end
      mm_pkg::TS_WDATA:
      begin
        next_shreg = byte_in;
        next_cnt   = cnt + 3'h1;
        if (cnt == 3'h7)
        begin
          // Committed at its ack, ahead of the closing stop
          next_req.data = byte_in;
          next_wr_tgl   = wr_tgl ^ sel_ok;
          next_drive    = sel_ok;
          next_state    = mm_pkg::TS_WDATA_ACK;
        end
      end
      mm_pkg::TS_WDATA_ACK:
      begin
        next_drive    = 1'b0;
        next_req.addr = req.addr + 8'h01;
        next_state    = mm_pkg::TS_WDATA;
      end
      mm_pkg::TS_RDATA:
      begin
        next_shreg = {shreg[6:0], 1'b0};
        next_cnt   = cnt + 3'h1;
        if (cnt == 3'h7)
        begin
          // Step early so the core has a whole bit time to refresh rd_byte
          next_drive    = 1'b0;
          next_req.addr = req.addr + 8'h01;
          next_state    = mm_pkg::TS_RACK;
        end
        else
          next_drive = ~shreg[6] & sel_ok;
      end
      mm_pkg::TS_RACK:
      begin
        next_cnt = 3'h0;
        if (!sda_p)
        begin
          // Host acked: send the next byte
          next_shreg  = rd_byte;
          next_drive  = ~rd_byte[7] & sel_ok;
          next_rd_tgl = ~rd_tgl;
          next_state  = mm_pkg::TS_RDATA;
        end
        else
          next_state = mm_pkg::TS_IDLE;
      end
      default:
        next_state = mm_pkg::TS_IDLE;
    endcase
    // Start restarts the address phase, stop ends the frame
    if (sda_p && !sda_in)
    begin
      next_state = mm_pkg::TS_ADDR;
      next_cnt   = 3'h0;
      next_drive = 1'b0;
    end
    else if (!sda_p && sda_in)
    begin
      next_state = mm_pkg::TS_IDLE;
      next_drive = 1'b0;
    end
  end

  // All protocol state moves on the falling edge, when sda may change
  always_ff @(negedge scl_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_s1    <= 1'b1;
      sel_s2    <= 1'b1;
      state     <= mm_pkg::TS_IDLE;
      shreg     <= 8'h00;
      cnt       <= 3'h0;
      sda_drive <= 1'b0;
      req       <= '0;
      wr_tgl    <= 1'b0;
      rd_tgl    <= 1'b0;
    end
    else
    begin
      sel_s1    <= select_n;
      sel_s2    <= sel_s1;
      state     <= next_state;
      shreg     <= next_shreg;
      cnt       <= next_cnt;
      sda_drive <= next_drive;
      req       <= next_req;
      wr_tgl    <= next_wr_tgl;
      rd_tgl    <= next_rd_tgl;
    end
  end

endmodule

`default_nettype wire

// ### design/mm_mgmt_ctrl.sv
// Management control of a pluggable transceiver: select gating, masks,
// power-down sequencing, readiness flag and laser enable.
// Assumes the host clocks the serial link and pulls sda and the
// interrupt line up; the laser and power stages sit outside.
`timescale 1ns/1ns
`default_nettype none

module mm_mgmt_ctrl
#(
  parameter int unsigned WAKE_CYCLES = mm_pkg::WAKE_CYCLES  // Wake and init wait
)
(
  input  wire logic        core_clk,             // 125 MHz core clock
  input  wire logic        resetn,               // Asynchronous, active low
  input  wire logic        scl_clk,              // Serial clock from the host
  input  wire logic        sda_in,               // Serial data line level
  output logic             sda_out,              // Always low: open drain
  output logic             sda_oe,               // High while pulling sda low
  input  wire logic        module_select_n,      // Module select, active low
  input  wire logic        transmit_disable_in,  // High or open turns the laser off
  input  wire logic [7:0]  flag_cond_in,         // Raw flag conditions, active high
  output logic             interrupt_out_n,      // Interrupt, active low
  output logic             low_power,            // Power stage to lower level
  output logic             laser_enable          // Laser output enable
);

  localparam int unsigned CW = $clog2(WAKE_CYCLES + 1);

  mm_pkg::mm_req_t         req;                  // Offset and data from the link
  logic                    wr_tgl;               // Write event, link domain
  logic                    rd_tgl;               // Read event, link domain
  logic                    drive;                // Slave wants sda low
  logic [7:0]              rd_byte;              // Byte offered to the link
  logic [7:0]              next_rd_byte;

  // Synchronisers: first stages read only by second stages
  logic [2:0]              wr_s;                 // Two stages plus edge history
  logic [2:0]              rd_s;
  logic [1:0]              drv_s;
  logic [1:0]              sel_s;
  logic [1:0]              transmit_disable_in_s;
  logic [7:0]              cond_s1;
  logic [7:0]              cond_s2;

  // Register map and power state
  logic                    power_down;
  logic                    next_power_down;
  logic [7:0]              mask;
  logic [7:0]              next_mask;
  logic [7:0]              flags;
  logic [7:0]              next_flags;
  logic                    dnr;                  // Data not ready
  logic                    next_dnr;
  logic                    ready_evt;            // Latched ready event
  logic                    next_ready_evt;
  mm_pkg::mm_pwr_state_t   pstate;
  mm_pkg::mm_pwr_state_t   next_pstate;
  logic [CW-1:0]           wait_cnt;
  logic [CW-1:0]           next_wait_cnt;
  logic                    wr_ev;
  logic                    rd_ev;
  logic                    next_int_n;
  logic                    next_laser;
  logic                    next_oe;

  // Byte as seen by the host at a given offset
  function automatic logic [7:0] map_read(input logic [7:0] ofs, input logic [7:0] st,
                                          input logic [7:0] fl, input logic [7:0] pw,
                                          input logic [7:0] mk);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      mm_pkg::STATUS_OFS: v = st;
      mm_pkg::FLAG_OFS:   v = fl;
      mm_pkg::PWR_OFS:    v = pw;
      mm_pkg::MASK_OFS:   v = mk;
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  mm_twi_slave mm_twi_slave_inst
  (
    .scl_clk   (scl_clk),
    .resetn    (resetn),
    .sda_in    (sda_in),
    .select_n  (module_select_n),
    .rd_byte   (rd_byte),
    .sda_drive (drive),
    .req       (req),
    .wr_tgl    (wr_tgl),
    .rd_tgl    (rd_tgl)
  );

  // Toggle edges mark one write or read; req holds for at least one bit time after each
  assign wr_ev = wr_s[2] ^ wr_s[1];
  assign rd_ev = rd_s[2] ^ rd_s[1];

  // Next values for the map, power sequence and outputs
  always_comb
  begin
    next_power_down = power_down;
    next_mask       = mask;
    next_pstate     = pstate;
    next_wait_cnt   = wait_cnt;
    next_dnr        = dnr;
    next_ready_evt  = ready_evt;
    // Host writes land in the map
    if (wr_ev && req.addr == mm_pkg::PWR_OFS)
      next_power_down = req.data[mm_pkg::PDOWN_BIT];
    if (wr_ev && req.addr == mm_pkg::MASK_OFS)
      next_mask = req.data;
    // Reads clear flags, a fresh condition wins over the clear
    next_flags = flags;
    if (rd_ev && req.addr == mm_pkg::FLAG_OFS)
      next_flags = 8'h00;
    next_flags = next_flags | cond_s2;
    if (rd_ev && req.addr == mm_pkg::STATUS_OFS)
      next_ready_evt = 1'b0;
    case (pstate)
      mm_pkg::PS_WAKE:
      begin
        if (power_down)
          next_pstate = mm_pkg::PS_LOW;
        else if (wait_cnt >= CW'(WAKE_CYCLES - 1))
        begin
          // Fully functional: not-ready drops, interrupt raised
          next_pstate    = mm_pkg::PS_FULL;
          next_dnr       = 1'b0;
          next_ready_evt = 1'b1;
        end
        else
          next_wait_cnt = wait_cnt + CW'(1);
      end
      mm_pkg::PS_FULL:
        if (power_down)
          next_pstate = mm_pkg::PS_LOW;
      mm_pkg::PS_LOW:
        if (!power_down)
        begin
          // Restart the wake wait with data marked not ready
          next_pstate   = mm_pkg::PS_WAKE;
          next_wait_cnt = '0;
          next_dnr      = 1'b1;
        end
      default:
        next_pstate = mm_pkg::PS_WAKE;
    endcase
    // Masks act on the very next cycle
    next_int_n = ~(|(flags & ~mask) | ready_evt);
    // Laser only while the pin is driven low and the power state is not PS_LOW
    next_laser = ~transmit_disable_in_s[1] & (next_pstate != mm_pkg::PS_LOW);
    // Deselect cuts the drive within three core cycles
    next_oe = drv_s[1] & ~sel_s[1];
    next_rd_byte = map_read(req.addr,
                            {7'h00, dnr} << mm_pkg::DNR_BIT,
                            flags,
                            {7'h00, power_down} << mm_pkg::PDOWN_BIT,
                            mask);
  end

  // Registers of the core domain
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_s            <= 3'h0;
      rd_s            <= 3'h0;
      drv_s           <= 2'h0;
      sel_s           <= 2'h3;
      transmit_disable_in_s          <= 2'h3;
      cond_s1         <= 8'h00;
      cond_s2         <= 8'h00;
      power_down      <= 1'b0;
      mask            <= mm_pkg::MASK_RESET;
      flags           <= mm_pkg::FLAG_RESET;
      dnr             <= 1'b1;
      ready_evt       <= 1'b0;
      pstate          <= mm_pkg::PS_WAKE;
      wait_cnt        <= '0;
      rd_byte         <= 8'h00;
      sda_out         <= 1'b0;
      sda_oe          <= 1'b0;
      interrupt_out_n <= 1'b1;
      low_power       <= 1'b0;
      laser_enable    <= 1'b0;
    end
    else
    begin
      wr_s            <= {wr_s[1:0], wr_tgl};
      rd_s            <= {rd_s[1:0], rd_tgl};
      drv_s           <= {drv_s[0], drive};
      sel_s           <= {sel_s[0], module_select_n};
      transmit_disable_in_s          <= {transmit_disable_in_s[0], transmit_disable_in};
      cond_s1         <= flag_cond_in;
      cond_s2         <= cond_s1;
      power_down      <= next_power_down;
      mask            <= next_mask;
      flags           <= next_flags;
      dnr             <= next_dnr;
      ready_evt       <= next_ready_evt;
      pstate          <= next_pstate;
      wait_cnt        <= next_wait_cnt;
      rd_byte         <= next_rd_byte;
      sda_out         <= 1'b0;
      sda_oe          <= next_oe;
      interrupt_out_n <= next_int_n;
      low_power       <= (next_pstate == mm_pkg::PS_LOW);
      laser_enable    <= next_laser;
    end
  end

endmodule

`default_nettype wire

// ### verif/mm_mgmt_ctrl_props.sv
// Checker for the management control block, bound to its top module.
// Assumes one core clock domain; the serial clock is watched as a level.
`timescale 1ns/1ns
`default_nettype none

module mm_mgmt_ctrl_props
#(
  parameter int unsigned WAKE_CYCLES = mm_pkg::WAKE_CYCLES  // Wake wait, as in the design
)
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       scl_clk,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       module_select_n,
  input wire logic       transmit_disable_in,
  input wire logic [7:0] flag_cond_in,
  input wire logic       interrupt_out_n,
  input wire logic       low_power,
  input wire logic       laser_enable
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  logic        wake_armed;  // Waiting for the ready interrupt
  int unsigned wake_cnt;    // Cycles spent waiting

  // Times a wake from reset or low power; an early interrupt only ends the wait
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_armed <= 1'b1;
      wake_cnt   <= 0;
    end
    else if (!interrupt_out_n || low_power)
    begin
      wake_armed <= low_power && interrupt_out_n;
      wake_cnt   <= 0;
    end
    else if (wake_armed)
      wake_cnt <= wake_cnt + 1;
  end

  // Pins held for longer than their synchroniser latency
  sequence s_deselected;
    module_select_n [*5];
  endsequence
  sequence s_tx_off;
    transmit_disable_in [*5];
  endsequence
  sequence s_tx_on;
    (!transmit_disable_in && !low_power) [*5];
  endsequence

  a_quiet_deselect: assert property (s_deselected |-> !sda_oe)
    else $error("sda pulled low while deselected");
  a_laser_off_transmit_disable_in: assert property (s_tx_off |=> !laser_enable)
    else $error("laser on while transmit disable high");
  a_laser_on_low: assert property (s_tx_on |=> laser_enable || low_power)
    else $error("laser off while transmit disable low");
  a_laser_lowpwr: assert property (laser_enable |-> !low_power)
    else $error("laser on in low power");
  a_open_drain: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("sda driven high");
  a_sda_scl_low: assert property ((!module_select_n) [*6] ##0 $changed(sda_oe) |-> !scl_clk)
    else $error("sda changed while scl high");
  a_reset_idle: assert property ($rose(resetn) |-> interrupt_out_n && !low_power && !sda_oe)
    else $error("outputs not idle after reset");
  a_wake_bound: assert property (wake_cnt <= WAKE_CYCLES + 4)
    else $error("ready interrupt late after wake");
endmodule

bind mm_mgmt_ctrl mm_mgmt_ctrl_props #(.WAKE_CYCLES(WAKE_CYCLES)) mm_mgmt_ctrl_props_inst
(
  .core_clk(core_clk), .resetn(resetn), .scl_clk(scl_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
  .transmit_disable_in(transmit_disable_in), .flag_cond_in(flag_cond_in),
  .interrupt_out_n(interrupt_out_n), .low_power(low_power), .laser_enable(laser_enable)
);
`default_nettype wire

// ### verif/mm_host_model.sv
// Host controller model on the 2-wire management link.
// Assumes sda has a pull-up outside; the clock stands high between frames.
`timescale 1ns/1ns
`default_nettype none

module mm_host_model
(
  output logic      scl_clk,  // Serial clock, still between frames
  output logic      sda_low,  // High while the host pulls sda low
  input  wire logic sda       // Wire level
);
  localparam int HALF = 40;   // 80 ns link clock

  initial
  begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end

  // One bit slot; data moves well after the fall so it never looks like a start
  task automatic slot(input logic b, output logic r);
    #10 sda_low = ~b;
    #30 scl_clk = 1'b1;
    r = sda;
    #HALF scl_clk = 1'b0;
  endtask

  // Start or repeated start; the odd delay keeps the link out of phase
  task automatic start;
    #3;
    if (!scl_clk)
    begin
      #10 sda_low = 1'b0;
      #30 scl_clk = 1'b1;
    end
    #HALF sda_low = 1'b1;
    #HALF scl_clk = 1'b0;
  endtask

  // Stop, then the falling edge from which write-triggered limits are timed
  task automatic stop;
    #10 sda_low = 1'b1;
    #30 scl_clk = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF scl_clk = 1'b0;
    #HALF scl_clk = 1'b1;
  endtask

  // Eight bits MSB first, then the ninth slot
  task automatic byte_io(input logic [7:0] tx, input logic last,
                         output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      slot(tx[i], rx[i]);
    slot(last, r);
    ack = ~r;
  endtask

  // Address, offset, data; ok only if every byte was acknowledged
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] dat, output logic ok);
    logic [7:0] junk;
    logic       a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, 1'b1, junk, a0);
    byte_io(ofs, 1'b1, junk, a1);
    byte_io(dat, 1'b1, junk, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // Offset write, repeated start, one byte read closed by a no-ack
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                          output logic [7:0] dat, output logic ok);
    logic [7:0] junk;
    logic       a0, a1, a2, a3;
    start();
    byte_io({dev, 1'b0}, 1'b1, junk, a0);
    byte_io(ofs, 1'b1, junk, a1);
    start();
    byte_io({dev, 1'b1}, 1'b1, junk, a2);
    byte_io(8'hff, 1'b1, dat, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// ### verif/test_module_mgmt_control_timing.sv
// Testbench of the management control block with a host model on the link.
// Assumes the design package is compiled first; wake count is shortened.
`timescale 1ns/1ns
`default_nettype none

module test_module_mgmt_control_timing;
  localparam int unsigned WAKE  = 2000;  // Shortened wake wait
  localparam int          LIMIT = 40000; // Run ceiling in core cycles
  localparam logic [6:0]  DEV   = mm_pkg::DEV_ADDR;

  logic       core_clk, resetn, scl_clk, host_low, sda_out, sda_oe;
  logic       module_select_n, transmit_disable_in, interrupt_out_n;
  logic       low_power, laser_enable, ok;
  logic [7:0] flag_cond_in, rv, v;
  wire        sda;
  int         bad_count = 0;
  int         checks = 0;
  int         cycles = 0;
  int         seed, n;

  // Pull-up wire; either party pulls it low
  assign sda = ~(host_low | (sda_oe & ~sda_out));

  mm_mgmt_ctrl #(.WAKE_CYCLES(WAKE)) mm_mgmt_ctrl_inst
  (
    .core_clk(core_clk), .resetn(resetn), .scl_clk(scl_clk), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
    .transmit_disable_in(transmit_disable_in), .flag_cond_in(flag_cond_in),
    .interrupt_out_n(interrupt_out_n), .low_power(low_power), .laser_enable(laser_enable)
  );
  mm_host_model mm_host_model_inst (.scl_clk(scl_clk), .sda_low(host_low), .sda(sda));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] d, input logic [7:0] ofs, input logic [7:0] dat,
                    input logic ack);
    mm_host_model_inst.write_reg(d, ofs, dat, ok);
    @(posedge core_clk);
    check({7'h0, ok}, {7'h0, ack});
  endtask

  task automatic rd(input logic [7:0] ofs);
    mm_host_model_inst.read_reg(DEV, ofs, rv, ok);
    @(posedge core_clk);
    check({7'h0, ok}, 8'h01);
  endtask

  // Bounded wait for the interrupt pin to reach a level
  task automatic wait_int(input logic lvl, input int lim);
    n = 0;
    while (interrupt_out_n !== lvl && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    check({7'h0, interrupt_out_n}, {7'h0, lvl});
  endtask

  // Flag conditions held briefly, then dropped so a read can clear them
  task automatic pulse(input logic [7:0] c);
    flag_cond_in <= c;
    repeat (4) @(posedge core_clk);
    flag_cond_in <= 8'h00;
    repeat (20) @(posedge core_clk);
  endtask

  // Expected interrupt level: low while any flag is set and unmasked
  function automatic logic [7:0] exp_int_n(input logic [7:0] fl, input logic [7:0] mk);
    return {7'h0, ~|(fl & ~mk)};
  endfunction

  initial
  begin
    seed = 32'h1c65;
    resetn = 1'b0;
    module_select_n = 1'b0;
    transmit_disable_in = 1'b1;
    flag_cond_in = 8'h00;
    repeat (20) @(posedge core_clk);
    check({5'h0, interrupt_out_n, low_power, sda_oe}, 8'h04);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(mm_pkg::STATUS_OFS);
    check({7'h0, rv[mm_pkg::DNR_BIT]}, 8'h01);
    wait_int(1'b0, WAKE);
    rd(mm_pkg::STATUS_OFS);
    check({7'h0, rv[mm_pkg::DNR_BIT]}, 8'h00);
    wait_int(1'b1, 100);
    $display("Test wake done");
    // Power down with the laser requested on, then wake again
    transmit_disable_in <= 1'b0;
    wr(DEV, mm_pkg::PWR_OFS, 8'h01, 1'b1);
    repeat (3) @(posedge core_clk);
    check({6'h0, low_power, laser_enable}, 8'h02);
    rd(mm_pkg::PWR_OFS);
    check({7'h0, rv[mm_pkg::PDOWN_BIT]}, 8'h01);
    wr(DEV, mm_pkg::PWR_OFS, 8'h00, 1'b1);
    wait_int(1'b0, WAKE + 8);
    check({6'h0, low_power, laser_enable}, 8'h01);
    rd(mm_pkg::STATUS_OFS);
    check({7'h0, rv[mm_pkg::DNR_BIT]}, 8'h00);
    wait_int(1'b1, 100);
    $display("Test power down done");
    repeat (16)
    begin
      v = 8'($random(seed));
      transmit_disable_in <= v[0];
      repeat (6) @(posedge core_clk);
      check({7'h0, laser_enable}, {7'h0, ~v[0]});
    end
    $display("Test laser done");
    // One flag unmasked at a time, random conditions on all eight
    for (int i = 0; i < 8; i++)
    begin
      wr(DEV, mm_pkg::MASK_OFS, ~(8'h01 << i), 1'b1);
      v = 8'($random(seed));
      pulse(v);
      check({7'h0, interrupt_out_n}, exp_int_n(v, ~(8'h01 << i)));
      rd(mm_pkg::FLAG_OFS);
      check(rv, v);
      wait_int(1'b1, 100);
    end
    // Pending flag held off by the mask, then released by clearing it
    wr(DEV, mm_pkg::MASK_OFS, 8'hff, 1'b1);
    pulse(8'h81);
    check({7'h0, interrupt_out_n}, exp_int_n(8'h81, 8'hff));
    wr(DEV, mm_pkg::MASK_OFS, 8'h00, 1'b1);
    wait_int(1'b0, 4);
    rd(mm_pkg::FLAG_OFS);
    check(rv, 8'h81);
    $display("Test masks done");
    // Deselected and misaddressed writes are refused; selected ones land
    module_select_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    wr(DEV, mm_pkg::MASK_OFS, 8'h5a, 1'b0);
    module_select_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr(DEV + 7'h01, mm_pkg::MASK_OFS, 8'h5a, 1'b0);
    rd(mm_pkg::MASK_OFS);
    check(rv, 8'h00);
    v = 8'($random(seed));
    wr(DEV, mm_pkg::MASK_OFS, v, 1'b1);
    rd(mm_pkg::MASK_OFS);
    check(rv, v);
    // Offsets outside the map read as zero
    rd(8'h40);
    check(rv, 8'h00);
    $display("Test select done");
    // Mid-run reset: outputs idle, mask back to its reset value, wake restarts
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({5'h0, interrupt_out_n, low_power, sda_oe}, 8'h04);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(mm_pkg::MASK_OFS);
    check(rv, mm_pkg::MASK_RESET);
    rd(mm_pkg::STATUS_OFS);
    check({7'h0, rv[mm_pkg::DNR_BIT]}, 8'h01);
    $display("Test reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
